// ==== fpr_defines.svh ====
// Constants for the fixed-point requantizer: widths, signedness, counts
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH
`define FPR_IN_W      16
`define FPR_IN_F      8
`define FPR_OUT_W     8
`define FPR_OUT_I     4
`define FPR_SIGNED    1
`define FPR_SAT_BITS  0
`define FPR_SYNC_LEN  2
`endif

// ==== fpr_pkg.sv ====
// Types of the fixed-point requantizer: modes and data carriers
`include "fpr_defines.svh"
package fpr_pkg;
  typedef enum logic [2:0] {
    round_plus_inf_mode       = 3'h0,
    round_toward_zero_mode    = 3'h1,
    round_minus_inf_mode      = 3'h2,
    round_infinity_mode       = 3'h3,
    round_convergent_mode     = 3'h4,
    truncate_mode             = 3'h5,
    truncate_toward_zero_mode = 3'h6
  } fpr_qmode_t;

  typedef enum logic [2:0] {
    saturate_mode            = 3'h0,
    saturate_to_zero_mode    = 3'h1,
    saturate_symmetric_mode  = 3'h2,
    wrap_around_mode         = 3'h3,
    sign_magnitude_wrap_mode = 3'h4
  } fpr_omode_t;

  typedef struct packed {
    logic                   valid;
    logic [`FPR_IN_W-1:0]   data;
  } fpr_in_t;

  typedef struct packed {
    logic                   valid;
    logic                   overflow;
    logic                   inexact;
    logic [`FPR_OUT_W-1:0]  data;
  } fpr_out_t;
endpackage

// ==== fpr_requantizer.sv ====
// Fixed-point requantizer: rounding of low bits, overflow of high bits
//
// Summary of operation
// - Round nearest, ties toward plus infinity
// - Round nearest, ties toward zero
// - Round nearest, ties toward minus infinity
// - Ties follow lsb and sign
// - Convergent: ties up when lsb set
// - Truncate: drop low bits, no correction
// - Truncate toward zero for negatives
// - Saturate overflow to max or min
// - Overflow in either direction gives zero
// - Symmetric saturation, negated max when signed
// - Wrap with zero count drops high bits
// - Wrap count N forces top bits one
// - Wrap count N keeps original sign
// - Sign-magnitude wrap takes lowest dropped bit
// - Sign mismatch inverts remaining bits
// - Sign-magnitude count N saturates, keeps sign
// - Signed or unsigned target chosen at elaboration
// - Fraction bits are width minus integer bits
// - Saturation count defaults to zero
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_requantizer #(
  parameter int                 IN_W     = `FPR_IN_W,
  parameter int                 IN_F     = `FPR_IN_F,
  parameter int                 W        = `FPR_OUT_W,
  parameter int                 I        = `FPR_OUT_I,
  parameter bit                 SIGNED   = `FPR_SIGNED,
  parameter fpr_pkg::fpr_qmode_t Q_MODE  = fpr_pkg::truncate_mode,
  parameter fpr_pkg::fpr_omode_t O_MODE  = fpr_pkg::wrap_around_mode,
  parameter int                 N        = `FPR_SAT_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Wide value from the upstream datapath
  input  wire fpr_pkg::fpr_in_t in_word,
  // Requantized result
  output fpr_pkg::fpr_out_t     out_word
);

  // Format geometry
  localparam int F  = W - I;
  localparam int D  = IN_F - F;
  localparam int QW = IN_W - D + 1;

  //////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic [`FPR_SYNC_LEN-1:0] rst_sync_reg;
  logic                     rst_n_sync;

  // Release asynchronous reset through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[`FPR_SYNC_LEN-2:0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_reg[`FPR_SYNC_LEN-1];

  //////////////////////////////////////////////////////////////////////
  // Quantization of the dropped low bits

  logic [IN_W-1:0] din;
  logic            neg;
  logic            half;
  logic            sticky;
  logic [QW-1:0]   trunc;
  logic            lsb;
  logic            inc;
  logic [QW-1:0]   q;

  // Split the input at the target binary point
  assign din    = in_word.data;
  assign neg    = din[IN_W-1];
  assign half   = din[D-1];
  assign sticky = (D > 1) ? |(din & ((IN_W'(1) << (D - 1)) - IN_W'(1)))
                          : 1'b0;
  assign trunc  = {neg, din[IN_W-1:D]};
  assign lsb    = trunc[0];

  // Increment decision per rounding mode
  always_comb begin
    case (Q_MODE)
      fpr_pkg::round_plus_inf_mode:
        inc = half;
      fpr_pkg::round_toward_zero_mode:
        inc = half & (sticky | neg);
      fpr_pkg::round_minus_inf_mode:
        inc = half & sticky;
      fpr_pkg::round_infinity_mode:
        inc = half & (sticky | (neg ? ~lsb : lsb));
      fpr_pkg::round_convergent_mode:
        inc = half & (sticky | lsb);
      fpr_pkg::truncate_mode:
        inc = 1'b0;
      fpr_pkg::truncate_toward_zero_mode:
        inc = neg & (half | sticky);
      default:
        inc = 1'b0;
    endcase
  end

  // Rounded value, one spare top bit for the carry
  assign q = trunc + {{(QW-1){1'b0}}, inc};

  //////////////////////////////////////////////////////////////////////
  // Overflow of the dropped high bits

  logic          qsign;
  logic          fits;
  logic          pos_ovf;
  logic          neg_ovf;
  logic [W-1:0]  max_val;
  logic [W-1:0]  min_val;
  logic [W-1:0]  sym_min;
  logic [W-1:0]  sat_mask;
  logic [W-1:0]  sm_low;
  logic [W-1:0]  result;

  // Range check against the target format
  assign qsign   = q[QW-1];
  assign fits    = SIGNED ? (&q[QW-1:W-1] | ~|q[QW-1:W-1])
                          : ~|q[QW-1:W];
  assign pos_ovf = ~fits & ~qsign;
  assign neg_ovf = ~fits & qsign;

  // Extreme values of the target format
  assign max_val  = SIGNED ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}};
  assign min_val  = SIGNED ? {1'b1, {(W-1){1'b0}}} : {W{1'b0}};
  assign sym_min  = SIGNED ? (~max_val + W'(1)) : {W{1'b0}};
  assign sat_mask = ~({W{1'b1}} >> N);

  // Sign-magnitude fold: lowest dropped bit against top kept bit
  genvar b;
  generate
    for (b = 0; b < W; b = b + 1) begin : g_sm
      assign sm_low[b] = q[b] ^ (q[W] ^ q[W-1]);
    end
  endgenerate

  // Final value per overflow mode
  always_comb begin
    result = q[W-1:0];
    case (O_MODE)
      fpr_pkg::saturate_mode: begin
        if (pos_ovf) result = max_val;
        if (neg_ovf) result = min_val;
      end
      fpr_pkg::saturate_to_zero_mode: begin
        if (!fits) result = {W{1'b0}};
      end
      fpr_pkg::saturate_symmetric_mode: begin
        if (pos_ovf) result = max_val;
        if (neg_ovf) result = sym_min;
      end
      fpr_pkg::wrap_around_mode: begin
        if (N > 0 && !fits) begin
          result = q[W-1:0] | sat_mask;
          if (SIGNED) result[W-1] = qsign;
        end
      end
      fpr_pkg::sign_magnitude_wrap_mode: begin
        result    = sm_low;
        result[W-1] = q[W];
        if (N > 0 && !fits) begin
          result = sm_low | sat_mask;
          if (SIGNED) result[W-1] = qsign;
        end
      end
      default: result = q[W-1:0];
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Output register

  // Result appears one clock after a valid input
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      out_word <= '0;
    end else begin
      out_word.valid    <= in_word.valid;
      out_word.overflow <= in_word.valid & ~fits;
      out_word.inexact  <= in_word.valid & (half | sticky);
      if (in_word.valid) begin
        out_word.data <= result;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Assertions

  logic [W-1:0] tl0;
  logic [W-1:0] tl1;
  logic         tie;
  logic [W-1:0] nosign_mask;

  // Reference values taken straight from the truncated input
  assign tl0         = trunc[W-1:0];
  assign tl1         = trunc[W-1:0] + W'(1);
  assign tie         = half & ~sticky;
  assign nosign_mask = sat_mask & {1'b0, {(W-1){1'b1}}};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_sync);

  a_format_legal: assert property (I <= W && D >= 1)
    else $error("target format wider than input");
  a_plus_tie: assert property (
    Q_MODE == fpr_pkg::round_plus_inf_mode && in_word.valid && tie && fits
    |=> out_word.data == $past(tl1))
    else $error("plus rounding tie not moved up");
  a_zero_tie: assert property (
    Q_MODE == fpr_pkg::round_toward_zero_mode && in_word.valid && tie
    && !neg && fits |=> out_word.data == $past(tl0))
    else $error("positive tie not moved toward zero");
  a_minf_tie: assert property (
    Q_MODE == fpr_pkg::round_minus_inf_mode && in_word.valid && tie && fits
    |=> out_word.data == $past(tl0))
    else $error("tie not moved toward minus infinity");
  a_inf_tie: assert property (
    Q_MODE == fpr_pkg::round_infinity_mode && in_word.valid && tie
    && !neg && lsb && fits |=> out_word.data == $past(tl1))
    else $error("positive odd tie not moved up");
  a_conv_tie: assert property (
    Q_MODE == fpr_pkg::round_convergent_mode && in_word.valid && tie
    && !lsb && fits |=> out_word.data == $past(tl0))
    else $error("even tie not moved down");
  a_trunc_drop: assert property (
    Q_MODE == fpr_pkg::truncate_mode && in_word.valid && fits
    |=> out_word.data == $past(tl0))
    else $error("truncation applied a correction");
  a_trzero_neg: assert property (
    Q_MODE == fpr_pkg::truncate_toward_zero_mode && in_word.valid && neg
    && (half || sticky) && fits |=> out_word.data == $past(tl1))
    else $error("negative value not moved toward zero");
  a_sat_clamp: assert property (
    O_MODE == fpr_pkg::saturate_mode && in_word.valid && !fits
    |=> out_word.data == (SIGNED ? ($past(qsign) ? min_val : max_val)
                                 : ($past(qsign) ? '0 : max_val)))
    else $error("saturation value wrong");
  a_satzero_out: assert property (
    O_MODE == fpr_pkg::saturate_to_zero_mode && in_word.valid && !fits
    |=> out_word.data == '0 && out_word.overflow)
    else $error("overflow did not give zero");
  a_sym_neg: assert property (
    O_MODE == fpr_pkg::saturate_symmetric_mode && in_word.valid && neg_ovf
    |=> out_word.data == sym_min)
    else $error("negative symmetric clamp wrong");
  a_wrap_plain: assert property (
    O_MODE == fpr_pkg::wrap_around_mode && N == 0 && in_word.valid
    |=> out_word.data == $past(q[W-1:0]))
    else $error("plain wrap did not drop high bits");
  a_wrap_satbits: assert property (
    O_MODE == fpr_pkg::wrap_around_mode && N > 0 && in_word.valid && !fits
    |=> (out_word.data & nosign_mask) == nosign_mask)
    else $error("saturated top bits not set");
  a_wrap_sign: assert property (
    O_MODE == fpr_pkg::wrap_around_mode && N > 0 && SIGNED
    && in_word.valid && !fits |=> out_word.data[W-1] == $past(qsign))
    else $error("wrap lost the original sign");
  a_sm_sign: assert property (
    O_MODE == fpr_pkg::sign_magnitude_wrap_mode && N == 0 && in_word.valid
    |=> out_word.data[W-1] == $past(q[W]))
    else $error("new sign is not lowest dropped bit");
  a_sm_invert: assert property (
    O_MODE == fpr_pkg::sign_magnitude_wrap_mode && N == 0 && in_word.valid
    && (q[W] != q[W-1])
    |=> out_word.data[W-2:0] == ~$past(q[W-2:0]))
    else $error("remaining bits not inverted");
  a_sm_satsign: assert property (
    O_MODE == fpr_pkg::sign_magnitude_wrap_mode && N > 0 && SIGNED
    && in_word.valid && !fits |=> out_word.data[W-1] == $past(qsign))
    else $error("sign-magnitude lost the sign");
  a_latency_one: assert property (
    in_word.valid |=> out_word.valid
    ##1 (out_word.valid == $past(in_word.valid)))
    else $error("result not registered one clock later");
  a_no_spurious: assert property (
    !in_word.valid |=> !out_word.valid && !out_word.overflow)
    else $error("valid without an input");

  //////////////////////////////////////////////////////////////////////
  // Further checks: non-tie rounding, other tie sides, clamps, flags

  // Nearest rounding away from a tie, and the other side of each tie
  a_plus_below: assert property (
    Q_MODE == fpr_pkg::round_plus_inf_mode && in_word.valid && !half
    && fits |=> out_word.data == $past(tl0))
    else $error("value below half step moved up");
  a_zero_above: assert property (
    Q_MODE == fpr_pkg::round_toward_zero_mode && in_word.valid && half
    && sticky && fits |=> out_word.data == $past(tl1))
    else $error("value above half step not moved up");
  a_zero_negtie: assert property (
    Q_MODE == fpr_pkg::round_toward_zero_mode && in_word.valid && tie
    && neg && fits |=> out_word.data == $past(tl1))
    else $error("negative tie not moved toward zero");
  a_minf_above: assert property (
    Q_MODE == fpr_pkg::round_minus_inf_mode && in_word.valid && half
    && sticky && fits |=> out_word.data == $past(tl1))
    else $error("value above half step not moved up");
  a_inf_negtie: assert property (
    Q_MODE == fpr_pkg::round_infinity_mode && in_word.valid && tie
    && neg && lsb && fits |=> out_word.data == $past(tl0))
    else $error("negative odd tie not moved down");
  a_conv_oddtie: assert property (
    Q_MODE == fpr_pkg::round_convergent_mode && in_word.valid && tie
    && lsb && fits |=> out_word.data == $past(tl1))
    else $error("odd tie not moved up");
  a_trzero_pos: assert property (
    Q_MODE == fpr_pkg::truncate_toward_zero_mode && in_word.valid
    && !neg && fits |=> out_word.data == $past(tl0))
    else $error("positive value corrected in truncation");

  // Positive overflow goes to the maximum in both clamping modes
  a_sat_max: assert property (
    O_MODE == fpr_pkg::saturate_mode && in_word.valid && pos_ovf
    |=> out_word.data == max_val)
    else $error("positive clamp not at maximum");
  a_sym_pos: assert property (
    O_MODE == fpr_pkg::saturate_symmetric_mode && in_word.valid && pos_ovf
    |=> out_word.data == max_val)
    else $error("positive symmetric clamp wrong");

  // Bits below the forced ones come from the rounded value, and sign-magnitude overflow sets the forced top bits
  a_wrap_low: assert property (
    O_MODE == fpr_pkg::wrap_around_mode && N > 0 && in_word.valid && !fits
    |=> (out_word.data & ~sat_mask) == ($past(q[W-1:0]) & ~sat_mask))
    else $error("wrap low bits not copied");
  a_sm_copy: assert property (
    O_MODE == fpr_pkg::sign_magnitude_wrap_mode && N == 0 && in_word.valid
    && (q[W] == q[W-1])
    |=> out_word.data[W-2:0] == $past(q[W-2:0]))
    else $error("remaining bits not copied");
  a_sm_satbits: assert property (
    O_MODE == fpr_pkg::sign_magnitude_wrap_mode && N > 0 && in_word.valid
    && !fits |=> (out_word.data & nosign_mask) == nosign_mask)
    else $error("sign-magnitude top bits not set");

  // Flags and held data follow the input of the edge before
  a_inexact_flag: assert property (
    in_word.valid |=> out_word.inexact == $past(half || sticky))
    else $error("inexact flag wrong");
  a_ovf_flag: assert property (
    in_word.valid |=> out_word.overflow == $past(!fits))
    else $error("overflow flag wrong");
  a_data_hold: assert property (
    !in_word.valid |=> $stable(out_word.data))
    else $error("data changed without an input");

  // Scenarios worth seeing
  c_overflow: cover property (in_word.valid && !fits ##1 out_word.overflow);
  c_tie: cover property (in_word.valid && tie ##1 out_word.inexact);
  c_burst: cover property (in_word.valid [*3]);
  c_neg_ovf: cover property (in_word.valid && neg_ovf ##1 out_word.overflow);
  c_gap: cover property (out_word.valid ##1 (!out_word.valid) [*2]);

endmodule

// ==== fpr_requantizer_tb_top.sv ====
// Testbench: streams words through every mode and judges each result
`timescale 1ns/1ps
module fpr_requantizer_tb_top;
  localparam int NCFG = 18;
  localparam int QV [NCFG] = '{0,1,2,3,4,5,6,0,5,5,5,5,5,5,5,5,5,5};
  localparam int OV [NCFG] = '{0,0,0,0,0,0,0,3,1,2,3,4,3,4,0,1,2,3};
  localparam int SV [NCFG] = '{1,1,1,1,1,1,1,1,1,1,1,1,1,1,0,0,0,0};
  localparam int NV [NCFG] = '{0,0,0,0,0,0,0,0,0,0,0,0,2,2,0,0,0,0};
  localparam logic [15:0] VEC [18] = '{16'h0018, 16'h0028, 16'hFFE8,
    16'hFFD8, 16'h0019, 16'hFFE9, 16'h07F8, 16'h0800, 16'hF7F0, 16'hF800,
    16'h1300, 16'hED00, 16'h7FF0, 16'h8000, 16'h0000, 16'hFFF7,
    16'h0107, 16'hF7F8};

  logic              clk;
  logic              rstn;
  fpr_pkg::fpr_in_t  in_word;
  fpr_pkg::fpr_out_t outs [NCFG];
  int                miscompares;
  int                num_checks;
  logic              hist_v;
  logic [15:0]       hist_x;
  logic [7:0]        held [NCFG];

  // Upstream source shared by every configuration
  fpr_upstream_model fpr_upstream_model_i (.clk(clk), .in_word(in_word));

  // One requantizer per mode combination
  for (genvar g = 0; g < NCFG; g++) begin : cfg
    fpr_requantizer #(
      .Q_MODE (fpr_pkg::fpr_qmode_t'(QV[g])),
      .O_MODE (fpr_pkg::fpr_omode_t'(OV[g])),
      .SIGNED (bit'(SV[g])),
      .N      (NV[g])
    ) fpr_requantizer_i (
      .clk(clk), .rstn(rstn), .in_word(in_word), .out_word(outs[g]));
  end

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////

  // Reference result {overflow, inexact, data} for configuration k
  function automatic logic [9:0] expect_out(input int k,
                                            input logic [15:0] x);
    logic signed [12:0] q;
    logic [7:0]         r;
    logic               ovf;
    logic               inc;
    int                 lo;
    int                 hi;
    lo = SV[k] ? -128 : 0;
    hi = SV[k] ? 127 : 255;
    q = {x[15], x[15:4]};
    case (QV[k])
      0: inc = x[3];
      1: inc = x[3] & ((|x[2:0]) | x[15]);
      2: inc = x[3] & (|x[2:0]);
      3: inc = x[3] & ((|x[2:0]) | (x[15] ^ q[0]));
      4: inc = x[3] & ((|x[2:0]) | q[0]);
      5: inc = 1'b0;
      default: inc = x[15] & (|x[3:0]);
    endcase
    q = q + 13'(inc);
    ovf = (q > hi) || (q < lo);
    r = q[7:0];
    if (OV[k] == 4) r = {q[8], (q[8] != q[7]) ? ~q[6:0] : q[6:0]};
    if (ovf) begin
      case (OV[k])
        0: r = (q < 0) ? 8'(lo) : 8'(hi);
        1: r = 8'h00;
        2: r = (q < 0) ? 8'(-hi * SV[k]) : 8'(hi);
        default: if (NV[k] > 0) begin
          r = r | ~(8'hFF >> NV[k]);
          r[7] = SV[k] ? q[12] : r[7];
        end
      endcase
    end
    return {ovf, |x[3:0], r};
  endfunction

  // Compares one value and counts the result
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Judges all outputs against the word taken one edge earlier
  task automatic judge(input logic v, input logic [15:0] x);
    logic [9:0] e;
    for (int k = 0; k < NCFG; k++) begin
      e = v ? expect_out(k, x) : {2'b00, held[k]};
      held[k] = e[7:0];
      check({7'h00, outs[k].valid}, {7'h00, v});
      check({7'h00, outs[k].inexact}, {7'h00, e[8]});
      check({7'h00, outs[k].overflow}, {7'h00, e[9]});
      if (k < 7) begin
        case (QV[k])
          0: check(outs[k].data, e[7:0]);
          1: check(outs[k].data, e[7:0]);
          2: check(outs[k].data, e[7:0]);
          3: check(outs[k].data, e[7:0]);
          4: check(outs[k].data, e[7:0]);
          5: check(outs[k].data, e[7:0]);
          default: check(outs[k].data, e[7:0]);
        endcase
      end else begin
        case (OV[k])
          0: check(outs[k].data, e[7:0]);
          1: check(outs[k].data, e[7:0]);
          2: check(outs[k].data, e[7:0]);
          3: check(outs[k].data, e[7:0]);
          default: check(outs[k].data, e[7:0]);
        endcase
      end
    end
  endtask

  // One falling-edge cycle: drive, then judge the word of the cycle before
  task automatic step(input logic v, input logic [15:0] x);
    if (v) fpr_upstream_model_i.put(x);
    else fpr_upstream_model_i.idle();
    judge(hist_v, hist_x);
    hist_v = v;
    hist_x = x;
  endtask

  // Reset for three cycles, then three quiet cycles after release
  task automatic apply_reset();
    rstn = 1'b0;
    hist_v = 1'b0;
    foreach (held[k]) held[k] = 8'h00;
    repeat (3) step(1'b0, 16'h0000);
    rstn = 1'b1;
    repeat (3) step(1'b0, 16'h0000);
  endtask

  // Back-to-back words, one per cycle
  task automatic scenario_stream();
    foreach (VEC[i]) step(1'b1, VEC[i]);
    repeat (2) step(1'b0, 16'h0000);
  endtask

  // Slow upstream: results must hold and flags drop between words
  task automatic scenario_gapped();
    foreach (VEC[i]) begin
      step(1'b1, VEC[i]);
      repeat (2) step(1'b0, 16'h0000);
    end
  endtask

  // Reset lands with words in flight, then traffic resumes
  task automatic scenario_mid_reset();
    step(1'b1, 16'h0018);
    step(1'b1, 16'h1300);
    apply_reset();
    step(1'b1, 16'hED00);
    repeat (2) step(1'b0, 16'h0000);
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    miscompares = 0;
    num_checks = 0;
    apply_reset();
    scenario_stream();
    scenario_gapped();
    scenario_mid_reset();
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule

// ==== fpr_upstream_model.sv ====
// Upstream datapath model that presents wide words to the requantizer
`timescale 1ns/1ps
module fpr_upstream_model (
  // Clock
  input  wire logic        clk,
  // Word towards the requantizer
  output fpr_pkg::fpr_in_t in_word
);
  // Quiet bus until the first word
  initial begin
    in_word = '0;
  end

  // Presents one word for one edge; back to back when called each cycle
  task automatic put(input logic [15:0] x);
    @(negedge clk);
    in_word.valid = 1'b1;
    in_word.data  = x;
  endtask

  // Slow cycle: no word, and stale data keeps changing
  task automatic idle();
    @(negedge clk);
    in_word.valid = 1'b0;
    in_word.data  = ~in_word.data;
  endtask
endmodule
